// >>> src/seec_engine.sv
`timescale 1ns/10ps
`include "seec_params.svh"

// What this block does
// - Every array word reads all ones before anything is written.
// - Data in is sampled on each rising serial clock while selected.
// - A frame ends when chip select falls; host keeps a deselect gap.
// - With chip select low the clock and data in are ignored.
// - First high sample after select rise is the start bit.
// - Low dummy clocks before the start bit have no effect.
// - Decode two-bit opcode, extended two-bit code for 00, rest ignored.
// - After the last read address bit, data out drives low one clock.
// - Then the addressed word shifts out, one bit per rising edge.
// - Continued clocking reads the next word without a new command.
// - Sequential read wraps from the top address to zero.
// - Programming starts at chip select fall after exact clock count.
// - During programming a read still runs, other commands are dropped; host must not send any.
// - Programming commands act only in program enable mode.
// - Programming finishes within the maximum time, typically half of it.
// - Reselecting after programming starts shows status on data out.
// - Status low while programming is still running.
// - Status high once programming has completed.
// - A high data in while ready is a start bit; host polls low.
// - Write enable sets, write disable clears mode at chip select fall.
// - Power-up or low supply cancels programming and forces disable mode.
// - Programming commands with a wrong clock count are cancelled.
// - Mode change takes effect at chip select fall after the address.
module seec_engine #(
  parameter int ADDR_W      = `SEEC_ADDR_W_DEF,
  parameter int DATA_W      = `SEEC_DATA_W,
  parameter int PROG_CYCLES = `SEEC_PROG_TYP_US * `SEEC_MCLK_MHZ
) (
  // System clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Supply monitor flag, asynchronous
  input  wire logic supply_low,
  // Serial link from the host
  input  wire logic chip_select,
  input  wire logic serial_clock,
  input  wire logic serial_data_in,
  // Serial data out pin, enable active low
  output logic      serial_data_out,
  output logic      serial_data_out_oe_n,
  // Status
  output logic      prog_busy,
  output logic      prog_enabled
);
  import seec_pkg::*;

  localparam int IN_W  = 2 + ADDR_W + DATA_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int RBW   = $clog2(DATA_W);
  localparam int TW    = $clog2(PROG_CYCLES + 1);

  localparam logic [`SEEC_CNT_W-1:0] CNT_SHORT = `SEEC_CNT_W'(`SEEC_HDR_BITS + ADDR_W);
  localparam logic [`SEEC_CNT_W-1:0] CNT_LONG  =
    `SEEC_CNT_W'(`SEEC_HDR_BITS + ADDR_W + DATA_W);
  localparam logic [RBW-1:0]         RBIT_TOP  = RBW'(DATA_W - 1);
  localparam logic [ADDR_W-1:0]      ADDR_TOP  = {ADDR_W{1'b1}};
  localparam logic [TW-1:0]          PROG_LAST = TW'(PROG_CYCLES - 1);

  // Cell array: written on mclk, read on the link clock
  logic [DATA_W-1:0] mem [DEPTH];

  // Link clock domain
  logic                   started_q;
  logic [`SEEC_CNT_W-1:0] cnt_q;
  logic [IN_W-1:0]        in_q;
  logic                   frame_tgl_q;
  logic                   rd_on_q;
  logic                   rd_load_q;
  logic [ADDR_W-1:0]      rd_addr_q;
  logic [DATA_W-1:0]      out_q;
  logic [RBW-1:0]         rd_bit_q;

  // System clock domain
  logic                   cs_s1_q;
  logic                   cs_s2_q;
  logic                   cs_s3_q;
  logic                   tgl_s1_q;
  logic                   tgl_s2_q;
  logic                   seen_q;
  logic                   low_s1_q;
  logic                   low_s2_q;
  seec_state_t            state_q;
  logic                   en_q;
  logic                   pend_q;
  logic                   all_q;
  logic                   swept_q;
  logic [ADDR_W-1:0]      pa_q;
  logic [DATA_W-1:0]      pw_q;
  logic [TW-1:0]          timer_q;

  // Factory state of the array, before any programming
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = `SEEC_BLANK_WORD;
    end
  end

  // ------------------------------------------------------------------
  // Link side: everything here moves on serial clock edges, apart from the async clears.
  // Chip select is the frame's own signal; it is set up to the clock by
  // the host, so it is read here directly and also clears the frame flags.
  // ------------------------------------------------------------------

  // Link decode
  wire                   link_live   = chip_select;
  wire                   start_bit   = link_live & ~started_q & serial_data_in;
  wire                   shift_bit   = link_live & started_q;
  wire seec_code_t       early_op    = in_q[ADDR_W:ADDR_W-1];
  wire                   last_a_edge = (cnt_q == CNT_SHORT - `SEEC_CNT_ONE);
  wire                   rd_hit      = shift_bit & last_a_edge
                                       & (early_op == `SEEC_OP_READ);
  wire [ADDR_W-1:0]      rd_addr_new = {in_q[ADDR_W-2:0], serial_data_in};
  wire                   cnt_full    = (cnt_q == `SEEC_CNT_SAT);
  wire [ADDR_W-1:0]      rd_addr_inc = rd_addr_q + 1'b1;

  // Start flag, held clear for the whole deselect time
  always_ff @(posedge serial_clock or negedge chip_select) begin
    if (!chip_select) begin
      started_q <= 1'b0;
    end else if (start_bit) begin
      started_q <= 1'b1; // Low samples before this are dummy clocks
    end
  end

  // Clock counter from the start bit; saturates so long frames never alias
  always_ff @(posedge serial_clock) begin
    if (start_bit) begin
      cnt_q <= `SEEC_CNT_ONE;
    end else if (shift_bit && !cnt_full) begin
      cnt_q <= cnt_q + `SEEC_CNT_ONE;
    end
  end

  // Opcode, address and data all pass through one shift register
  always_ff @(posedge serial_clock) begin
    if (start_bit) begin
      in_q <= '0;
    end else if (shift_bit) begin
      in_q <= {in_q[IN_W-2:0], serial_data_in};
    end
  end

  // One toggle per frame with a start bit; tells mclk a command exists
  always_ff @(posedge serial_clock or negedge nrst) begin
    if (!nrst) begin
      frame_tgl_q <= 1'b0;
    end else if (start_bit) begin
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // Read output enable; released as soon as the frame ends
  always_ff @(posedge serial_clock or negedge chip_select) begin
    if (!chip_select) begin
      rd_on_q   <= 1'b0;
      rd_load_q <= 1'b0;
    end else if (rd_hit) begin
      rd_on_q   <= 1'b1; // Drive the low dummy bit
      rd_load_q <= 1'b1;
    end else begin
      rd_load_q <= 1'b0;
    end
  end

  // Read shifter; reads are not blocked during programming, so the array can change under a read
  always_ff @(posedge serial_clock) begin
    if (rd_hit) begin
      rd_addr_q <= rd_addr_new;
      out_q     <= '0;
      rd_bit_q  <= '0;
    end else if (rd_on_q && link_live) begin
      if (rd_load_q) begin
        out_q    <= mem[rd_addr_q];
        rd_bit_q <= RBIT_TOP;
      end else if (rd_bit_q != '0) begin
        out_q    <= {out_q[DATA_W-2:0], 1'b0};
        rd_bit_q <= rd_bit_q - 1'b1;
      end else begin
        rd_addr_q <= rd_addr_inc;
        out_q     <= mem[rd_addr_inc];
        rd_bit_q  <= RBIT_TOP;
      end
    end
  end

  // ------------------------------------------------------------------
  // System side: frame end, command execution and programming timer.
  // ------------------------------------------------------------------

  // Synchronisers for chip select, the frame toggle and the supply flag
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cs_s1_q  <= 1'b0;
      cs_s2_q  <= 1'b0;
      cs_s3_q  <= 1'b0;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      low_s1_q <= 1'b0;
      low_s2_q <= 1'b0;
    end else begin
      cs_s1_q  <= chip_select;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      tgl_s1_q <= frame_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      low_s1_q <= supply_low;
      low_s2_q <= low_s1_q;
    end
  end

  // Frame end detect. The link registers are read only after the
  // synchronised fall: the link clock is still by then, so they are static.
  wire frame_end = cs_s3_q & ~cs_s2_q;
  wire new_cmd   = frame_end & (tgl_s2_q != seen_q);

  // Field decode of the captured frame, by its exact clock count
  wire                is_short = (cnt_q == CNT_SHORT);
  wire                is_long  = (cnt_q == CNT_LONG);
  wire seec_code_t    s_op     = in_q[ADDR_W+1:ADDR_W];
  wire seec_code_t    s_ext    = in_q[ADDR_W-1:ADDR_W-2];
  wire [ADDR_W-1:0]   s_addr   = in_q[ADDR_W-1:0];
  wire seec_code_t    l_op     = in_q[IN_W-1:IN_W-2];
  wire seec_code_t    l_ext    = in_q[IN_W-3:IN_W-4];
  wire [ADDR_W-1:0]   l_addr   = in_q[IN_W-3:DATA_W];
  wire [DATA_W-1:0]   l_data   = in_q[DATA_W-1:0];

  // Command selection; surplus address bits of extended codes are don't care
  wire do_erase      = is_short & (s_op == `SEEC_OP_ERASE);
  wire do_chip_erase = is_short & (s_op == `SEEC_OP_EXT)
                       & (s_ext == `SEEC_EXT_CHIP_ERASE);
  wire do_wen        = is_short & (s_op == `SEEC_OP_EXT)
                       & (s_ext == `SEEC_EXT_WEN);
  wire do_wdis       = is_short & (s_op == `SEEC_OP_EXT)
                       & (s_ext == `SEEC_EXT_WDIS);
  wire do_write      = is_long & (l_op == `SEEC_OP_WRITE);
  wire do_chip_write = is_long & (l_op == `SEEC_OP_EXT)
                       & (l_ext == `SEEC_EXT_CHIP_WRITE);
  wire do_prog       = do_erase | do_chip_erase | do_write | do_chip_write;

  // Commands arriving while busy or under low supply are dropped
  wire is_prog = (state_q == SEEC_PROG);
  wire take    = new_cmd & ~is_prog & ~low_s2_q;
  wire prog_go = take & en_q & do_prog;
  wire go_all  = do_chip_erase | do_chip_write;
  wire go_ers  = do_erase | do_chip_erase;

  // Programming word and first address
  wire [DATA_W-1:0] go_word = go_ers ? `SEEC_BLANK_WORD : l_data;
  wire [ADDR_W-1:0] go_addr = go_all ? '0 : (do_erase ? s_addr : l_addr);

  // Cell writes: one word per cycle, so a chip-wide sweep ends long before the timer
  wire mem_we   = is_prog & ~swept_q;
  wire sweep_ok = ~all_q | (pa_q == ADDR_TOP);
  wire prog_end = is_prog & (timer_q == PROG_LAST);

  // Mark the toggle as consumed, busy or not, so it never replays
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      seen_q <= 1'b0;
    end else if (new_cmd) begin
      seen_q <= tgl_s2_q;
    end
  end

  // Program enable mode
  always_ff @(posedge mclk) begin
    if (!nrst || low_s2_q) begin
      en_q <= 1'b0;
    end else if (take && do_wen) begin
      en_q <= 1'b1;
    end else if (take && do_wdis) begin
      en_q <= 1'b0;
    end
  end

  // Programming state
  always_ff @(posedge mclk) begin
    if (!nrst || low_s2_q) begin
      state_q <= SEEC_IDLE;
    end else begin
      unique case (state_q)
        SEEC_IDLE: begin
          if (prog_go) begin
            state_q <= SEEC_PROG;
          end
        end
        SEEC_PROG: begin
          if (prog_end) begin
            state_q <= SEEC_IDLE;
          end
        end
      endcase
    end
  end

  // Busy timer; a fixed typical duration within the maximum bound
  always_ff @(posedge mclk) begin
    if (!nrst || prog_go) begin
      timer_q <= '0;
    end else if (is_prog) begin
      timer_q <= timer_q + 1'b1;
    end
  end

  // Target address, word and sweep control
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pa_q    <= '0;
      pw_q    <= '0;
      all_q   <= 1'b0;
      swept_q <= 1'b1;
    end else if (prog_go) begin
      pa_q    <= go_addr;
      pw_q    <= go_word;
      all_q   <= go_all;
      swept_q <= 1'b0;
    end else if (mem_we) begin
      pa_q    <= sweep_ok ? pa_q : pa_q + 1'b1;
      swept_q <= sweep_ok;
    end
  end

  // Array write port; supply loss mid-write leaves the rest unwritten.
  // Plain always: the factory fill in the initial block writes it too
  always @(posedge mclk) begin
    if (mem_we && !low_s2_q) begin
      mem[pa_q] <= pw_q;
    end
  end

  // Status polling owed after a programming start, until the next command
  always_ff @(posedge mclk) begin
    if (!nrst || low_s2_q) begin
      pend_q <= 1'b0;
    end else if (new_cmd) begin
      pend_q <= prog_go;
    end
  end

  // ------------------------------------------------------------------
  // Data out pin. Read data has priority; otherwise the status shows
  // while selected after a programming start, until a start bit is seen, which releases the pin.
  // ------------------------------------------------------------------
  wire poll_show = chip_select & pend_q & ~started_q;
  wire ready_lvl = ~is_prog;

  assign serial_data_out      = rd_on_q ? out_q[DATA_W-1] : ready_lvl;
  assign serial_data_out_oe_n = ~(rd_on_q | poll_show);
  assign prog_busy            = is_prog;
  assign prog_enabled         = en_q;

endmodule

// >>> include/seec_params.svh
`ifndef SEEC_PARAMS_SVH
`define SEEC_PARAMS_SVH

// Array shape
`define SEEC_ADDR_W_DEF     6
`define SEEC_DATA_W         16
`define SEEC_BLANK_WORD     16'hFFFF

// Frame layout: start bit plus two operation bits ahead of the address
`define SEEC_HDR_BITS       3
`define SEEC_CNT_W          6
`define SEEC_CNT_SAT        6'h3F
`define SEEC_CNT_ONE        6'h01

// Operation codes, first two bits after the start bit
`define SEEC_OP_EXT         2'h0
`define SEEC_OP_WRITE       2'h1
`define SEEC_OP_READ        2'h2
`define SEEC_OP_ERASE       2'h3

// Extended codes, the two bits after an EXT operation code
`define SEEC_EXT_WDIS       2'h0
`define SEEC_EXT_CHIP_WRITE 2'h1
`define SEEC_EXT_CHIP_ERASE 2'h2
`define SEEC_EXT_WEN        2'h3

// Timing
`define SEEC_MCLK_MHZ       125
`define SEEC_PROG_TYP_US    4000
`define SEEC_PROG_MAX_US    8000

`endif

// >>> include/seec_pkg.sv
package seec_pkg;

  // Programming engine states
  typedef enum logic {
    SEEC_IDLE,
    SEEC_PROG
  } seec_state_t;

  // Two-bit code fields of a frame
  typedef logic [1:0] seec_code_t;

endpackage

// >>> tb/seec_properties.sv
`timescale 1ns/10ps
// Watches the engine pins for mode, busy and status behaviour
module seec_props #(
  parameter int ADDR_W      = 6,
  parameter int DATA_W      = 16,
  parameter int PROG_CYCLES = 50
) (
  // System side
  input wire logic mclk,
  input wire logic nrst,
  input wire logic supply_low,
  // Serial link
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe_n,
  // Status
  input wire logic prog_busy,
  input wire logic prog_enabled
);
  logic [31:0] busy_len_q;
  logic [31:0] busy_len_d;

  // Busy length counter, restarts whenever idle
  assign busy_len_d = prog_busy ? busy_len_q + 32'h1 : 32'h0;
  always_ff @(posedge mclk) busy_len_q <= nrst ? busy_len_d : 32'h0;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Status shown on data out during a poll
  sequence poll_on;
    chip_select && !serial_data_out_oe_n;
  endsequence
  sequence busy_start;
    $rose(prog_busy);
  endsequence
  // Sync flops need a few cycles before the flag acts
  sequence low_held;
    supply_low [*4];
  endsequence

  standby_release_a: assert property (!chip_select |-> serial_data_out_oe_n)
    else $error("data out driven while deselected");
  status_busy_a: assert property (poll_on and prog_busy |-> !serial_data_out)
    else $error("status not low while busy");
  ready_status_a: assert property ($fell(prog_busy) ##2 poll_on |-> serial_data_out)
    else $error("status not high after completion");
  busy_length_a: assert property ($fell(prog_busy) |-> busy_len_q == PROG_CYCLES)
    else $error("busy period has wrong length");
  busy_needs_en_a: assert property (busy_start |-> $past(prog_enabled))
    else $error("programming started while disabled");
  busy_at_deselect_a: assert property (busy_start |-> !chip_select && !$past(chip_select, 2))
    else $error("programming started with select high");
  mode_at_deselect_a: assert property ($rose(prog_enabled) |-> !chip_select)
    else $error("enable mode changed inside a frame");
  supply_drop_a: assert property (low_held |=> !prog_enabled && !prog_busy)
    else $error("low supply did not force disable");
endmodule

bind seec_engine seec_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .PROG_CYCLES(PROG_CYCLES))
  seec_props_i (.mclk(mclk), .nrst(nrst), .supply_low(supply_low), .chip_select(chip_select),
  .serial_clock(serial_clock), .serial_data_in(serial_data_in),
  .serial_data_out(serial_data_out), .serial_data_out_oe_n(serial_data_out_oe_n),
  .prog_busy(prog_busy), .prog_enabled(prog_enabled));

// >>> tb/seec_host.sv
`timescale 1ns/10ps
// Host end of the link: frames, dummy clocks and select handling
module seec_host (
  // Link toward the engine
  output logic      chip_select,
  output logic      serial_clock,
  output logic      serial_data_in,
  // Resolved data out wire
  input  wire logic data_wire
);
  localparam int HALF = 80;
  logic [63:0] got;

  // Select drops a moment in, so the engine's async frame clear sees an edge
  initial begin
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
    #1 chip_select = 1'b0;
  end

  // Deselect gap kept after every drop; data in idles off its last value
  task automatic sel(input logic v);
    chip_select = v;
    serial_data_in = v ? 1'b0 : ~serial_data_in;
    #(v ? HALF : 5 * HALF);
  endtask

  // Bits change with the clock low; clock stands still outside frames except in noise
  task automatic frame(input logic [63:0] bits, input int n, input int pre);
    int i;
    got = 64'h0;
    #7;
    sel(1'b1);
    for (i = 0; i < pre + n; i++) begin
      serial_data_in = (i < pre) ? 1'b0 : bits[n - 1 - (i - pre)];
      #HALF serial_clock = 1'b1;
      #(HALF / 2) got = {got[62:0], data_wire};
      #(HALF / 2) serial_clock = 1'b0;
    end
    sel(1'b0);
  endtask

  // Clock and data activity while deselected
  task automatic noise();
    int i;
    serial_data_in = 1'b1;
    for (i = 0; i < 3; i++) begin
      #HALF serial_clock = 1'b1;
      #HALF serial_clock = 1'b0;
    end
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  localparam int PC = 400;
  logic        mclk, nrst, supply_low, chip_select, serial_clock, serial_data_in;
  logic        serial_data_out, serial_data_out_oe_n, prog_busy, prog_enabled;
  wire         data_wire;
  logic [15:0] exp_mem [64];
  logic [5:0]  a;
  logic [15:0] d;
  logic [15:0] w;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          i;
  integer      seed;

  // No pull on the data out wire, so a released pin reads z
  assign data_wire = serial_data_out_oe_n ? 1'bz : serial_data_out;

  seec_engine #(.ADDR_W(6), .PROG_CYCLES(PC)) seec_engine_i (.mclk(mclk), .nrst(nrst),
    .supply_low(supply_low), .chip_select(chip_select), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe_n(serial_data_out_oe_n), .prog_busy(prog_busy),
    .prog_enabled(prog_enabled));
  seec_host seec_host_i (.chip_select(chip_select), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .data_wire(data_wire));

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  // Hang guard, well above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // Frame bits: start bit, two op bits, address, optional data word
  function automatic logic [63:0] cmd(input logic [1:0] op, input logic [5:0] ad,
                                      input logic [15:0] dt, input logic wd);
    return wd ? {39'h0, 1'b1, op, ad, dt} : {55'h0, 1'b1, op, ad};
  endfunction

  // One command, then a status poll when programming is expected
  task automatic run(input logic [1:0] op, input logic [5:0] ad, input logic [15:0] dt,
                     input logic wd, input logic prog);
    int k;
    seec_host_i.frame(cmd(op, ad, dt, wd), wd ? 25 : 9, 0);
    `CHK("busy", prog, prog_busy)
    if (prog) begin
      seec_host_i.sel(1'b1);
      `CHK("status", 1'b0, data_wire)
      for (k = 0; k < 2000 && prog_busy === 1'b1; k++) @(negedge mclk);
      repeat (4) @(negedge mclk);
      `CHK("ready", 1'b1, data_wire)
      seec_host_i.sel(1'b0);
    end
  endtask

  // Read two consecutive words after a random run of dummy clocks
  task automatic rd2(input logic [5:0] ad);
    logic [63:0] g;
    seec_host_i.frame({23'h0, 3'h6, ad, 32'h0}, 41, {$random(seed)} % 8);
    g = seec_host_i.got;
    `CHK("dummy bit", 1'b0, g[32])
    `CHK("word", exp_mem[ad], g[31:16])
    `CHK("next word", exp_mem[ad + 6'h1], g[15:0])
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    seed = 32'h9aec0f27;
    supply_low = 1'b0;
    for (i = 0; i < 64; i++) exp_mem[i] = 16'hFFFF;
    // Reset lands a moment in, so the link side's async clear sees an edge
    #1 nrst = 1'b0;
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    seec_host_i.noise();
    a = 6'($random(seed));
    rd2(a);
    $display("test blank read done");
    // Write refused while disabled, wrong-count enable refused too
    d = 16'($random(seed));
    run(2'h1, a, d, 1'b1, 1'b0);
    run(2'h0, 6'h30, 16'h0, 1'b1, 1'b0);
    `CHK("enabled", 1'b0, prog_enabled)
    run(2'h0, 6'h3A, 16'h0, 1'b0, 1'b0);
    `CHK("enabled", 1'b1, prog_enabled)
    $display("test enable done");
    // Random word writes, each read back with its neighbour
    for (i = 0; i < 3; i++) begin
      a = 6'($random(seed));
      d = 16'($random(seed));
      run(2'h1, a, d, 1'b1, 1'b1);
      exp_mem[a] = d;
      rd2(a);
    end
    run(2'h3, a, 16'h0, 1'b1, 1'b0);
    rd2(a);
    $display("test word write done");
    // Chip write, top word write, wrap read, erase, chip erase
    w = 16'($random(seed));
    run(2'h0, 6'h15, w, 1'b1, 1'b1);
    for (i = 0; i < 64; i++) exp_mem[i] = w;
    run(2'h1, 6'h3F, d, 1'b1, 1'b1);
    exp_mem[63] = d;
    rd2(6'h3F);
    run(2'h3, 6'h3F, 16'h0, 1'b0, 1'b1);
    exp_mem[63] = 16'hFFFF;
    rd2(6'h3E);
    run(2'h0, 6'h2C, 16'h0, 1'b0, 1'b1);
    for (i = 0; i < 64; i++) exp_mem[i] = 16'hFFFF;
    rd2(a);
    $display("test chip ops done");
    // Disable, then enable again and drop the supply
    run(2'h0, 6'h07, 16'h0, 1'b0, 1'b0);
    `CHK("enabled", 1'b0, prog_enabled)
    run(2'h1, a, d, 1'b1, 1'b0);
    run(2'h0, 6'h31, 16'h0, 1'b0, 1'b0);
    @(negedge mclk) supply_low = 1'b1;
    repeat (8) @(negedge mclk);
    supply_low = 1'b0;
    repeat (4) @(negedge mclk);
    `CHK("enabled", 1'b0, prog_enabled)
    $display("test disable done");
    give_verdict();
  end
endmodule
